// File: bld_pkg.sv
// Purpose: shared constants and types for the boost led driver control
// Assumes: 100 MHz system clock
// Notes:   references are expressed as digital codes in microvolts
package bld_pkg;
  localparam int unsigned CLK_HZ          = 100_000_000;
  localparam int unsigned SW_FREQ_HZ      = 600_000;
  localparam int unsigned SW_PERIOD_CYC   = CLK_HZ / SW_FREQ_HZ;
  localparam int unsigned SW_CNT_W        = 8;
  localparam int unsigned OVP_CYCLES      = 8;
  localparam int unsigned OVP_CNT_W       = 4;
  localparam int unsigned SD_TIME_US      = 2500;
  localparam int unsigned SD_TIME_CYC     = (SD_TIME_US * (CLK_HZ / 1_000_000));
  localparam int unsigned LOW_CNT_W       = 20;
  localparam int unsigned REF_W           = 16;
  localparam int unsigned REF_FULL_UV     = 300_000;
  localparam int unsigned REF_OFFSET_UV   = 850;
  localparam int unsigned REF_UV_W        = 20;
  localparam int unsigned FILT_SHIFT      = 14;
  localparam int unsigned FILT_W          = REF_UV_W + FILT_SHIFT;
  localparam int unsigned SS_STEP_UV      = 1;
  localparam int unsigned SS_W            = 20;

  typedef enum logic [1:0] {
    BLD_OFF,
    BLD_RUN,
    BLD_OVP_LATCH
  } bld_state_t;

  typedef struct packed {
    logic supply_undervoltage_lockout;
    logic otp;
    logic ovp;
  } bld_faults_t;

  typedef struct packed {
    logic [REF_UV_W-1:0] ref_uv;
    logic [SS_W-1:0]     ea_limit_uv;
  } bld_ref_t;
endpackage

// File: bld_control.sv
// Purpose: enable sequencing, fault handling, switching cycle, dimming reference
// Assumes: comparator inputs synchronous to i_clk; i_reset_n synchronous
// Notes:   analog filter and error amplifier modelled as digital codes in uV
// Notes on behaviour
// - switching period derived from 600 kHz at system clock rate
// - switch turns on at cycle start, off when current reaches threshold
// - over-voltage seen eight consecutive cycles turns switch off and shuts down
// - over-voltage shutdown stays latched until enable goes low then high
// - shutdown only after enable input stays low longer than 2.5 ms
// - constant high enable gives full 300 mV regulation target
// - reference gated by dimming phases then low-pass filtered into amplifier
// - target equals duty times 300 mV plus 0.85 mV offset
// - reference depends on input timing only, never its voltage level
// - undervoltage turns switch off, state stays run, and blocks start from off; resumes automatically when it clears
// - over-temperature turns switch off, state stays run; resumes automatically when it clears
// - long low enable inhibits switching and enters reduced-current state
// - enable high with supply good activates switching and soft-start
// - amplifier output ramps slowly after each enable
`timescale 1ns/10ps
module bld_control
  import bld_pkg::*;
#(
  parameter int unsigned SD_CYC = SD_TIME_CYC
) (
  // clock and reset
  input  wire logic                i_clk,
  input  wire logic                i_reset_n,
  // host dimming and enable
  input  wire logic                i_dim_enable,
  // analog indications
  input  wire logic                i_current_at_limit,
  input  wire logic                i_switch_overvoltage,
  input  wire logic                i_supply_undervoltage_lockout,
  input  wire logic                i_over_temperature,
  // power stage and references
  output logic                     o_switch_on,
  output logic                     o_active,
  output logic                     o_low_power,
  output logic [REF_UV_W-1:0]      o_ref_uv,
  output logic [SS_W-1:0]          o_ea_limit_uv,
  output bld_faults_t              o_faults
);

  bld_state_t           state;
  bld_state_t           next_state;
  logic [SW_CNT_W-1:0]  sw_cnt;
  logic [SW_CNT_W-1:0]  next_sw_cnt;
  logic                 sw_on;
  logic                 next_sw_on;
  logic                 cyc_ovp;
  logic                 next_cyc_ovp;
  logic [OVP_CNT_W-1:0] ovp_cnt;
  logic [OVP_CNT_W-1:0] next_ovp_cnt;
  logic [LOW_CNT_W-1:0] low_cnt;
  logic [LOW_CNT_W-1:0] next_low_cnt;
  logic                 shut;
  logic                 next_shut;
  logic                 dim_q;
  logic [FILT_W-1:0]    filt;
  logic [FILT_W-1:0]    next_filt;
  logic [SS_W-1:0]      ss;
  logic [SS_W-1:0]      next_ss;
  bld_faults_t          faults;
  bld_ref_t             refs;
  bld_ref_t             next_refs;
  logic                 run_ok;
  logic                 cyc_end;
  logic [REF_UV_W-1:0]  chopped;

  // supply or heat faults stop switching but leave the state in run
  always_comb begin
    run_ok  = (state == BLD_RUN) && !i_supply_undervoltage_lockout && !i_over_temperature;
    cyc_end = (sw_cnt == SW_CNT_W'(SW_PERIOD_CYC - 1));
  end

  // low time of the enable input; short lows are only dimming phases
  always_comb begin
    next_low_cnt = low_cnt;
    next_shut    = shut;
    if (i_dim_enable && !dim_q) begin
      next_low_cnt = '0;
      next_shut    = 1'b0;
    end else if (!i_dim_enable) begin
      if (low_cnt < LOW_CNT_W'(SD_CYC)) begin
        next_low_cnt = low_cnt + 1'b1;
      end else begin
        next_shut = 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      low_cnt <= '0;
      shut    <= 1'b1;
      dim_q   <= 1'b0;
    end else begin
      low_cnt <= next_low_cnt;
      shut    <= next_shut;
      dim_q   <= i_dim_enable;
    end
  end

  // switching cycle and count of over-voltage cycles
  always_comb begin
    next_sw_cnt  = cyc_end ? '0 : sw_cnt + 1'b1;
    next_sw_on   = sw_on;
    next_cyc_ovp = cyc_ovp | i_switch_overvoltage;
    next_ovp_cnt = ovp_cnt;
    if (!run_ok) begin
      next_sw_on   = 1'b0;
      next_sw_cnt  = '0;
      next_cyc_ovp = 1'b0;
      next_ovp_cnt = '0;
    end else if (cyc_end) begin
      next_sw_on   = 1'b1;
      next_cyc_ovp = 1'b0;
      if (cyc_ovp | i_switch_overvoltage) begin
        next_ovp_cnt = ovp_cnt + 1'b1;
      end else begin
        next_ovp_cnt = '0;
      end
    end else if (i_current_at_limit) begin
      next_sw_on = 1'b0;
    end
    // the last bad cycle drops the gate on the same edge that latches
    if ((state == BLD_RUN) && (next_ovp_cnt >= OVP_CNT_W'(OVP_CYCLES))) begin
      next_sw_on = 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      sw_cnt  <= '0;
      sw_on   <= 1'b0;
      cyc_ovp <= 1'b0;
      ovp_cnt <= '0;
    end else begin
      sw_cnt  <= next_sw_cnt;
      sw_on   <= next_sw_on;
      cyc_ovp <= next_cyc_ovp;
      ovp_cnt <= next_ovp_cnt;
    end
  end

  // operating state
  always_comb begin
    next_state = state;
    case (state)
      BLD_OFF: begin
        if (!next_shut && i_dim_enable && !i_supply_undervoltage_lockout) begin
          next_state = BLD_RUN;
        end
      end
      BLD_RUN: begin
        if (next_ovp_cnt >= OVP_CNT_W'(OVP_CYCLES)) begin
          next_state = BLD_OVP_LATCH;
        end else if (next_shut) begin
          next_state = BLD_OFF;
        end
      end
      BLD_OVP_LATCH: begin
        // only a low on the enable releases the latch to off; a later high restarts
        if (!i_dim_enable) begin
          next_state = BLD_OFF;
        end
      end
      default: next_state = BLD_OFF;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      state  <= BLD_OFF;
      faults <= '0;
    end else begin
      state  <= next_state;
      faults <= '{supply_undervoltage_lockout: i_supply_undervoltage_lockout, otp: i_over_temperature,
                  ovp: (next_state == BLD_OVP_LATCH)};
    end
  end

  // dimming reference and soft-start ramp
  always_comb begin
    // reference chopped by logic level of input only
    chopped = i_dim_enable ? REF_UV_W'(REF_FULL_UV) : '0;
    // first-order filter; settles to duty times full scale
    next_filt = filt - (filt >> FILT_SHIFT) + FILT_W'(chopped);
    if (state != BLD_RUN) begin
      next_ss = '0;
    end else if (ss < SS_W'(REF_FULL_UV)) begin
      next_ss = ss + SS_W'(SS_STEP_UV);
    end else begin
      next_ss = ss;
    end
    next_refs.ref_uv      = REF_UV_W'(filt >> FILT_SHIFT) + REF_UV_W'(REF_OFFSET_UV);
    next_refs.ea_limit_uv = ss;
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      filt <= '0;
      ss   <= '0;
      refs <= '0;
    end else begin
      filt <= next_filt;
      ss   <= next_ss;
      refs <= next_refs;
    end
  end

  assign o_switch_on   = sw_on;
  assign o_active      = (state == BLD_RUN);
  assign o_low_power   = (state != BLD_RUN);
  assign o_ref_uv      = refs.ref_uv;
  assign o_ea_limit_uv = refs.ea_limit_uv;
  assign o_faults      = faults;
endmodule

// File: bld_monitor.sv
// Purpose: port checker for bld_control
// Assumes: one clock, sync active-low reset
// Notes:   low-time counter is helper logic
`timescale 1ns/10ps
module bld_monitor
  import bld_pkg::*;
#(
  parameter int unsigned SD_CYC = SD_TIME_CYC
) (
  // clock and reset
  input  wire logic                i_clk,
  input  wire logic                i_reset_n,
  // block inputs
  input  wire logic                i_dim_enable,
  input  wire logic                i_current_at_limit,
  input  wire logic                i_switch_overvoltage,
  input  wire logic                i_supply_undervoltage_lockout,
  input  wire logic                i_over_temperature,
  // block outputs
  input  wire logic                o_switch_on,
  input  wire logic                o_active,
  input  wire logic                o_low_power,
  input  wire logic [REF_UV_W-1:0] o_ref_uv,
  input  wire logic [SS_W-1:0]     o_ea_limit_uv,
  input  wire bld_faults_t         o_faults
);
  logic [LOW_CNT_W-1:0] low_cnt;
  always_ff @(posedge i_clk)
    low_cnt <= (!i_reset_n || i_dim_enable) ? '0 : low_cnt + 1'b1;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  sequence s_rise;
    !i_dim_enable ##1 i_dim_enable;
  endsequence
  a_limit_ends_on: assert property (o_switch_on && i_current_at_limit |=> !o_switch_on)
    else $error("switch on past limit");
  a_ovp_off: assert property (o_faults.ovp |-> !o_switch_on && !o_active)
    else $error("running while latched");
  a_latch_holds: assert property (o_faults.ovp && i_dim_enable |=> o_faults.ovp)
    else $error("latch left without toggle");
  a_short_low: assert property (
    low_cnt < SD_CYC - 2 && $past(o_active) && !o_faults.ovp |-> o_active)
    else $error("short low stopped device");
  a_long_low: assert property (low_cnt > SD_CYC + 2 |-> !o_active)
    else $error("long low kept device on");
  a_supply_undervoltage_lockout_off: assert property (i_supply_undervoltage_lockout |=> !o_switch_on)
    else $error("switch on in lockout");
  a_hot_off: assert property (i_over_temperature |=> !o_switch_on)
    else $error("switch on while hot");
  a_enable_start: assert property (
    s_rise ##0 !i_supply_undervoltage_lockout |-> ##[1:2] o_active)
    else $error("enable did not start");
  a_soft_ramp: assert property (
    o_active && $past(o_active) |-> o_ea_limit_uv <= $past(o_ea_limit_uv) + 20'h00001)
    else $error("ramp stepped");
endmodule
bind bld_control bld_monitor #(.SD_CYC(SD_CYC)) mon (.*);

// File: bld_host.sv
// Purpose: host driving the dimming/enable pin
// Assumes: shares the block clock
// Notes:   pwm at 100 kHz, half duty
`timescale 1ns/10ps
module bld_host (
  input  wire logic i_clk,
  input  wire logic i_level,
  input  wire logic i_pwm,
  output logic      o_dim
);
  logic [9:0] cnt = 10'h000;
  logic [9:0] next_cnt;
  always_comb next_cnt = (cnt == 10'h3e7) ? 10'h000 : cnt + 10'h001;
  always_ff @(posedge i_clk) cnt <= next_cnt;
  assign o_dim = i_pwm ? (cnt < 10'h1f4) : i_level;
endmodule

// File: bld_control_test.sv
// Purpose: self-checking bench for bld_control
// Assumes: shutdown delay cut to 2000 clocks
// Notes:   current limit follows switch by one clock
`timescale 1ns/10ps
module bld_control_test;
  import bld_pkg::*;
  localparam int unsigned SD = 2000;
  logic i_clk = 1'b0, i_reset_n = 1'b0, lvl = 1'b0, pwm = 1'b0, i_dim_enable;
  logic i_current_at_limit = 1'b0, ovp = 1'b0, supply_undervoltage_lockout = 1'b0, otp = 1'b0;
  logic o_switch_on, o_active, o_low_power;
  logic [REF_UV_W-1:0] o_ref_uv, r;
  logic [SS_W-1:0] o_ea_limit_uv;
  bld_faults_t o_faults;
  int fail_count = 0, comparisons = 0;
  bld_host host (.i_clk(i_clk), .i_level(lvl), .i_pwm(pwm), .o_dim(i_dim_enable));
  bld_control #(.SD_CYC(SD)) uut (.i_clk(i_clk), .i_reset_n(i_reset_n),
    .i_dim_enable(i_dim_enable), .i_current_at_limit(i_current_at_limit),
    .i_switch_overvoltage(ovp), .i_supply_undervoltage_lockout(supply_undervoltage_lockout),
    .i_over_temperature(otp), .o_switch_on(o_switch_on), .o_active(o_active),
    .o_low_power(o_low_power), .o_ref_uv(o_ref_uv), .o_ea_limit_uv(o_ea_limit_uv),
    .o_faults(o_faults));
  initial forever #5 i_clk = ~i_clk;
  always @(posedge i_clk) i_current_at_limit <= o_switch_on;
  task automatic chk(string n, logic [19:0] e, logic [19:0] s);
    comparisons++;
    if (s !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic tick(int n); repeat (n) @(posedge i_clk); endtask
  task automatic wait_on(output int c);
    c = 0;
    while (o_switch_on !== 1'b1 && c < 400) begin @(negedge i_clk); c++; end
  endtask
  task automatic t_start;
    int c;
    tick(1); lvl <= 1'b1;
    tick(2); @(negedge i_clk); chk("active", 1, o_active);
    chk("low_power", 0, o_low_power);
    wait_on(c); chk("switch", 1, o_switch_on);
    c = 0;
    while (o_switch_on && c < 400) begin @(negedge i_clk); c++; end
    while (!o_switch_on && c < 400) begin @(negedge i_clk); c++; end
    chk("period", 166, c);
    chk("ramp", 1, o_ea_limit_uv > 0 && o_ea_limit_uv < REF_FULL_UV);
  endtask
  task automatic t_ref;
    tick(20000); @(negedge i_clk); r = o_ref_uv;
    chk("ref_full", 1, r > 150000 && r <= 300850);
    tick(1); pwm <= 1'b1; tick(20000); @(negedge i_clk);
    chk("ref_dim", 1, o_ref_uv < r && o_ref_uv > 150850);
    chk("pwm_run", 1, o_active);
    tick(1); pwm <= 1'b0;
  endtask
  task automatic t_fault(bit hot);
    int c;
    tick(1); if (hot) otp <= 1'b1; else supply_undervoltage_lockout <= 1'b1;
    tick(400); @(negedge i_clk); chk("held_off", 0, o_switch_on);
    chk("fault_flag", 1, hot ? o_faults.otp : o_faults.supply_undervoltage_lockout);
    tick(1); otp <= 1'b0; supply_undervoltage_lockout <= 1'b0;
    wait_on(c); chk("resumed", 1, o_switch_on);
    chk("flag_clear", 0, o_faults.otp | o_faults.supply_undervoltage_lockout);
  endtask
  task automatic t_ovp;
    tick(1); ovp <= 1'b1; tick(996); ovp <= 1'b0;
    tick(400); ovp <= 1'b1; tick(996); ovp <= 1'b0;
    @(negedge i_clk); chk("ovp_early", 0, o_faults.ovp);
    tick(400); ovp <= 1'b1; tick(1494); ovp <= 1'b0;
    @(negedge i_clk); chk("ovp_latch", 1, o_faults.ovp);
    tick(1); lvl <= 1'b0; tick(5); lvl <= 1'b1;
    tick(3); @(negedge i_clk); chk("restart", 1, o_active);
  endtask
  task automatic t_shut;
    tick(1); lvl <= 1'b0; tick(SD - 10); @(negedge i_clk);
    chk("short_low", 1, o_active);
    tick(20); @(negedge i_clk); chk("shut", 1, o_low_power);
  endtask
  task automatic complete_run;
    if (fail_count == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial begin
    tick(4); i_reset_n <= 1'b1;
    t_start; t_ref; t_fault(1'b0); t_fault(1'b1); t_ovp; t_shut;
    complete_run;
  end
  initial begin #1_000_000; fail_count++; complete_run; end
endmodule
